/* bench/cwgd_top_test.sv */
// cwgd_top_test: self-checking bench for the dead-band delay block
// assumes cwgd_top and cwgd_pkg are compiled first; 40 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module cwgd_top_test;
  import cwgd_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0;
  logic       wave = 1'b0, sd = 1'b0, oa, oa_oe, ob, ob_oe, pol_a = 1'b0;
  logic [1:0] addr = 2'h0, div = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, q;
  int         n_errors = 0, compares = 0, d;

  cwgd_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_fast_osc_tick(tick), .i_wave(wave),
    .i_shutdown(sd), .i_pol_a(pol_a), .i_pol_b(1'b0), .o_out_a(oa),
    .o_out_a_oe(oa_oe), .o_out_b(ob), .o_out_b_oe(ob_oe));

  always #12.5 clk = ~clk;
  // fast oscillator stand-in: one tick every fourth core cycle
  always @(posedge clk) begin
    div  <= div + 2'h1;
    tick <= (div == 2'h3);
  end
  always @(negedge clk) if (rst_n && oa === 1'b1 && ob === 1'b1) begin
    n_errors++;
    $display("[ERR] %0t got %h exp %h", $time, {oa, ob}, 2'h2);
  end

  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  // cycles from the input edge until the chosen output goes active
  task automatic lat(input logic want_b, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (((want_b ? ob : oa) !== 1'b1) && n < 400);
  endtask : lat

  task automatic edge_t(input logic fall, input logic [5:0] n, input int per);
    wreg(fall ? CWGD_ADDR_FALL : CWGD_ADDR_RISE, {2'h0, n});
    @(posedge clk);
    wave <= fall;
    repeat (300) @(posedge clk);
    wave <= !fall;
    lat(fall, d);
    `CHK(d >= n * per && d <= (n + 1) * per + 3, 1'b1)
    $display("edge test fall=%0d n=%0d took %0d cycles", fall, n, d);
  endtask : edge_t

  task automatic reg_t();
    wreg(CWGD_ADDR_RISE, 8'hFF);
    wreg(CWGD_ADDR_FALL, 8'hC0);
    rreg(CWGD_ADDR_RISE, q);
    `CHK(q, 8'h3F)
    rreg(CWGD_ADDR_FALL, q);
    `CHK(q, 8'h00)
    wreg(CWGD_ADDR_FALL, 8'hEA);
    rreg(CWGD_ADDR_FALL, q);
    `CHK(q, 8'h2A)
    $display("register test done");
  endtask : reg_t

  task automatic shut_t();
    wreg(CWGD_ADDR_CTRL, 8'h00);
    wreg(CWGD_ADDR_RISE, 8'h02);
    wave <= 1'b1;
    repeat (20) @(posedge clk);
    pol_a <= 1'b1;
    sd <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    `CHK({oa, oa_oe}, 2'h3)
    @(posedge clk);
    sd <= 1'b0;
    pol_a <= 1'b0;
    $display("shutdown test done");
  endtask : shut_t

  task automatic keep_t();
    wreg(CWGD_ADDR_RISE, 8'h15);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({oa, ob, rdata}, 10'h000)
    @(posedge clk);
    rst_n <= 1'b1;
    rreg(CWGD_ADDR_RISE, q);
    `CHK(q, 8'h15)
    $display("reset keep test done");
  endtask : keep_t

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wreg(CWGD_ADDR_CTRL, 8'h00);
    reg_t();
    edge_t(1'b0, 6'h00, 1);
    edge_t(1'b0, 6'h01, 1);
    edge_t(1'b0, 6'h3F, 1);
    edge_t(1'b1, 6'h02, 1);
    edge_t(1'b1, 6'h00, 1);
    wreg(CWGD_ADDR_CTRL, 8'h01);
    edge_t(1'b0, 6'h02, 4);
    edge_t(1'b1, 6'h03, 4);
    shut_t();
    keep_t();
    complete_run();
  end

  initial begin
    #200us;
    n_errors++;
    complete_run();
  end
endmodule : cwgd_top_test
`default_nettype wire

/* verilog/cwgd_dly_if.sv */
// cwgd_dly_if: carries one edge-delay request and its result
// assumes both ends share i_core_clk
`timescale 1ns/1ps
`default_nettype none
interface cwgd_dly_if;
  logic       tick;
  logic [5:0] count;
  logic       level_in;
  logic       level_out;
  logic       busy;
  modport ctl (output tick, output count, output level_in, input level_out, input busy);
  modport dly (input tick, input count, input level_in, output level_out, output busy);
endinterface : cwgd_dly_if
`default_nettype wire

/* verilog/cwgd_edge_dly.sv */
// cwgd_edge_dly: delays the rising edge of a level by N to N+1 ticks
// assumes tick is a one-cycle enable from the dead-band clock divider
`timescale 1ns/1ps
`default_nettype none
module cwgd_edge_dly
  import cwgd_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // delay request
  cwgd_dly_if.dly   dl
);
  import cwgd_pkg::*;
  logic [5:0] cnt_q;
  logic       out_q;
  logic       run_q;

  assign dl.level_out = out_q;
  assign dl.busy      = run_q;

  // falling edges pass at once; rising edges wait count+1 ticks, none if count is zero, so the delay is N to N+1
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= CWGD_CNT_ZERO;
      run_q <= 1'b0;
      out_q <= 1'b0;
    end else if (!dl.level_in) begin
      run_q <= 1'b0;
      out_q <= 1'b0;
    end else if (dl.count == CWGD_CNT_ZERO) begin
      out_q <= 1'b1;
    end else if (!out_q && !run_q) begin
      run_q <= 1'b1;
      cnt_q <= dl.count;
    end else if (run_q && dl.tick) begin
      if (cnt_q == CWGD_CNT_ZERO) begin
        run_q <= 1'b0;
        out_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end

  a_dly_drop_fast: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !dl.level_in |=> !out_q)
    else $error("delayed output did not drop with input");
endmodule : cwgd_edge_dly
`default_nettype wire

/* verilog/cwgd_pkg.sv */
// cwgd_pkg: constants for the dead-band delay block
// assumes a plain 8-bit register port, one 40 MHz core clock
package cwgd_pkg;
  localparam int          CWGD_CNT_W       = 6;
  localparam int          CWGD_ADDR_W      = 2;
  localparam int          CWGD_DATA_W      = 8;
  localparam logic [1:0]  CWGD_ADDR_RISE   = 2'h0;
  localparam logic [1:0]  CWGD_ADDR_FALL   = 2'h1;
  localparam logic [1:0]  CWGD_ADDR_CTRL   = 2'h2;
  localparam logic [1:0]  CWGD_ADDR_STAT   = 2'h3;
  localparam int          CWGD_CTRL_CS_BIT = 0;
  localparam int          CWGD_CTRL_ASA_LO = 4;
  localparam int          CWGD_CTRL_ASB_LO = 6;
  localparam logic [1:0]  CWGD_SDL_INACT   = 2'h0;
  localparam logic [1:0]  CWGD_SDL_TRI     = 2'h1;
  localparam logic [1:0]  CWGD_SDL_LOW     = 2'h2;
  localparam logic [1:0]  CWGD_SDL_HIGH    = 2'h3;
  localparam logic [5:0]  CWGD_CNT_ZERO    = 6'h00;
  localparam logic [7:0]  CWGD_CTRL_RST    = 8'h00;
endpackage : cwgd_pkg

/* verilog/cwgd_top.sv */
// cwgd_top: dead-band delay of a complementary waveform pair
// assumes synchronous inputs, fast oscillator tick given as an enable
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cwgd_top
  import cwgd_pkg::*;
(
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst_n,
  // register port
  input  wire logic [cwgd_pkg::CWGD_ADDR_W-1:0] i_addr,
  input  wire logic [cwgd_pkg::CWGD_DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic [cwgd_pkg::CWGD_DATA_W-1:0] o_rdata,
  // waveform and shutdown
  input  wire logic                        i_fast_osc_tick,
  input  wire logic                        i_wave,
  input  wire logic                        i_shutdown,
  input  wire logic                        i_pol_a,
  input  wire logic                        i_pol_b,
  // outputs
  output logic                             o_out_a,
  output logic                             o_out_a_oe,
  output logic                             o_out_b,
  output logic                             o_out_b_oe
);
  import cwgd_pkg::*;

  logic [5:0] rise_cnt_q;
  logic [5:0] fall_cnt_q;
  logic [7:0] ctrl_q;
  logic       tick;
  logic       a_act;
  logic       b_act;
  logic       a_q;
  logic       b_q;
  logic       a_oe_q;
  logic       b_oe_q;
  logic [7:0] rdata_q;
  logic [1:0] sdl_a;
  logic [1:0] sdl_b;
  logic       sd_a_inact;
  logic       sd_b_inact;

  cwgd_dly_if rise_if ();
  cwgd_dly_if fall_if ();

  assign sdl_a = ctrl_q[CWGD_CTRL_ASA_LO +: 2];
  assign sdl_b = ctrl_q[CWGD_CTRL_ASB_LO +: 2];
  assign sd_a_inact = i_shutdown && sdl_a == CWGD_SDL_INACT;
  assign sd_b_inact = i_shutdown && sdl_b == CWGD_SDL_INACT;

  // count fields have no reset on purpose
  always_ff @(posedge i_core_clk) begin
    if (i_wr && i_addr == CWGD_ADDR_RISE) begin
      rise_cnt_q <= i_wdata[CWGD_CNT_W-1:0];
    end
    if (i_wr && i_addr == CWGD_ADDR_FALL) begin
      fall_cnt_q <= i_wdata[CWGD_CNT_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= CWGD_CTRL_RST;
    end else if (i_wr && i_addr == CWGD_ADDR_CTRL) begin
      ctrl_q <= i_wdata;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        CWGD_ADDR_RISE: rdata_q <= {2'h0, rise_cnt_q};
        CWGD_ADDR_FALL: rdata_q <= {2'h0, fall_cnt_q};
        CWGD_ADDR_CTRL: rdata_q <= ctrl_q;
        CWGD_ADDR_STAT: rdata_q <= {4'h0, rise_if.busy, fall_if.busy, b_q, a_q};
        default:        rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  // dead-band clock select
  assign tick = ctrl_q[CWGD_CTRL_CS_BIT] ? i_fast_osc_tick : 1'b1;

  assign rise_if.tick     = tick;
  assign rise_if.count    = rise_cnt_q;
  assign rise_if.level_in = i_wave && !sd_a_inact;
  assign fall_if.tick     = tick;
  assign fall_if.count    = fall_cnt_q;
  assign fall_if.level_in = !i_wave && !sd_b_inact;

  cwgd_edge_dly u_rise (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .dl         (rise_if)
  );
  cwgd_edge_dly u_fall (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .dl         (fall_if)
  );

  // shutdown masks the delayed levels directly so the inactive level comes at once, with no dead band
  assign a_act = rise_if.level_out && !i_shutdown;
  assign b_act = fall_if.level_out && !i_shutdown;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_q    <= 1'b0;
      b_q    <= 1'b0;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      a_oe_q <= !(i_shutdown && sdl_a == CWGD_SDL_TRI);
      b_oe_q <= !(i_shutdown && sdl_b == CWGD_SDL_TRI);
      if (i_shutdown && sdl_a[1]) begin
        a_q <= sdl_a == CWGD_SDL_HIGH;
      end else begin
        a_q <= a_act ^ i_pol_a;
      end
      if (i_shutdown && sdl_b[1]) begin
        b_q <= sdl_b == CWGD_SDL_HIGH;
      end else begin
        b_q <= b_act ^ i_pol_b;
      end
    end
  end
  assign o_out_a    = a_q;
  assign o_out_b    = b_q;
  assign o_out_a_oe = a_oe_q;
  assign o_out_b_oe = b_oe_q;

  a_never_both_on: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !(rise_if.level_out && fall_if.level_out))
    else $error("both outputs active together");
  a_rise_zero_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (rise_cnt_q == CWGD_CNT_ZERO && $stable(rise_cnt_q) && i_wave && !sd_a_inact)
    |=> rise_if.level_out)
    else $error("zero rising count delayed output");
  a_fall_zero_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (fall_cnt_q == CWGD_CNT_ZERO && $stable(fall_cnt_q) && !i_wave && !sd_b_inact)
    |=> fall_if.level_out)
    else $error("zero falling count not bypassed");
  a_rise_not_early: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($rose(i_wave) && rise_cnt_q != CWGD_CNT_ZERO) |=> !rise_if.level_out)
    else $error("rising edge passed without dead band");
  a_fall_not_early: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(i_wave) && fall_cnt_q != CWGD_CNT_ZERO) |=> !fall_if.level_out)
    else $error("falling edge passed without dead band");
  a_rise_sysclk: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($rose(i_wave) && rise_cnt_q == 6'h02 && !ctrl_q[CWGD_CTRL_CS_BIT] && i_wave[*1])
    ##1 i_wave[*4] |-> rise_if.level_out)
    else $error("rising delay of two counts too long");
  a_rdata_rise: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == CWGD_ADDR_RISE) |=> o_rdata == {2'h0, $past(rise_cnt_q)})
    else $error("rising count read wrong");
  a_rdata_fall: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == CWGD_ADDR_FALL) |=> o_rdata[7:6] == 2'h0)
    else $error("falling count upper bits not zero");
  a_sd_inactive: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_shutdown && sdl_a == CWGD_SDL_INACT && !rise_if.level_out) |=> o_out_a == $past(i_pol_a))
    else $error("shutdown inactive level wrong");
  a_wr_kept: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == CWGD_ADDR_RISE) |=> rise_cnt_q == $past(i_wdata[5:0]))
    else $error("rising count not stored");
endmodule : cwgd_top
`default_nettype wire
